// ### sarseq_pkg.sv
/*
 Package for the successive-approximation converter sequencer:
 register offsets, field positions, reset values, timing counts, carrier types.
 Assumes a 100 MHz aclk and 32-bit AXI4-Lite register access.
*/
package sarseq_pkg;

    // Register byte offsets
    localparam logic [7:0] SARSEQ_OFF_CTRL    = 8'h00;
    localparam logic [7:0] SARSEQ_OFF_OPTIONS = 8'h04;
    localparam logic [7:0] SARSEQ_OFF_SLOT1   = 8'h08;
    localparam logic [7:0] SARSEQ_OFF_SLOT2   = 8'h0c;
    localparam logic [7:0] SARSEQ_OFF_SLOT3   = 8'h10;
    localparam logic [7:0] SARSEQ_OFF_SLOT4   = 8'h14;
    localparam logic [7:0] SARSEQ_OFF_POWER   = 8'h18;

    // Control/status field positions
    localparam int SARSEQ_CTL_DONE_BIT = 7;
    localparam int SARSEQ_CTL_SCAN_BIT = 5;
    localparam int SARSEQ_CTL_GRP_BIT  = 4;

    // Options field positions
    localparam int SARSEQ_OPT_PU_BIT   = 7;
    localparam int SARSEQ_OPT_CONV_CLOCK_SELECT_BIT = 6;
    localparam int SARSEQ_OPT_DLY_BIT  = 4;

    // Reset values
    localparam logic [7:0] SARSEQ_CTRL_RST = 8'h00;
    localparam logic [7:0] SARSEQ_OPT_RST  = 8'h10;
    localparam logic [7:0] SARSEQ_OPT_MASK = 8'hd0;

    // Conversion timing, in conversion clock cycles
    localparam int         SARSEQ_NUM_BITS    = 8;
    localparam int         SARSEQ_NUM_SLOTS   = 4;
    localparam logic [4:0] SARSEQ_SAMPLE_CYC  = 5'h0c;
    localparam logic [4:0] SARSEQ_CONV_CYC    = 5'h1f;
    localparam logic [4:0] SARSEQ_STEP_FIRST  = 5'h0c;
    localparam logic [4:0] SARSEQ_STEP_LAST   = 5'h13;

    // Option write window and stop-exit delays, in bus cycles
    localparam logic [6:0]  SARSEQ_WRONCE_CYC  = 7'h40;
    localparam int          SARSEQ_DLY_LONG    = 4000;
    localparam int          SARSEQ_DLY_SHORT   = 4;
    localparam logic [11:0] SARSEQ_DLY_LONG_C  = 12'(SARSEQ_DLY_LONG);
    localparam logic [11:0] SARSEQ_DLY_SHORT_C = 12'(SARSEQ_DLY_SHORT);

    // RC clock divider default: one enable per this many aclk cycles
    localparam logic [3:0] SARSEQ_RC_DIV = 4'h4;

    // AXI responses
    localparam logic [1:0] SARSEQ_RESP_OKAY   = 2'b00;
    localparam logic [1:0] SARSEQ_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SARSEQ_IDLE    = 2'b00,
        SARSEQ_RUN     = 2'b01,
        SARSEQ_SUSPEND = 2'b10,
        SARSEQ_RESUME  = 2'b11
    } sarseq_state_t;

    // Analog front end controls
    typedef struct packed {
        logic       power_up;
        logic       sample_closed;
        logic [3:0] source_select_code;
        logic [7:0] dac_code;
    } sarseq_afe_t;

endpackage

// ### sarseq_top.sv
/*
 Sequencer for an 8-bit successive-approximation converter, with AXI4-Lite
 registers. Assumes the analog mux, capacitor DAC and comparator sit outside,
 the comparator answering within the conversion clock step it is sampled on.
*/
`timescale 1ns/10ps
// What this block does
// - Eight comparison steps per conversion, MSB first
// - Finished approximation copied into its slot
// - Sample switch closed twelve cycles per conversion
// - Four readable 8-bit result slots
// - Slot updates never collide with reads
// - Clock select: bus clock or RC clock
// - Sequences of four, one-shot or continuous
// - Done flag set after fourth conversion
// - Power-up bit enables converter, clear powers down
// - Sequence starts one cycle after control write
// - Low reference gives 00, high gives ff
// - Sixteen sources; group source n to slot n mod 4
// - Single one-shot: four results, then halt
// - Single continuous: slot index wraps around
// - Group one-shot: each source once, then halt
// - Group continuous: cycles group, slots wrap
// - Stop/wait suspends channel, resamples on resume
// - Stop exit delay 4000 or about four cycles
// - Write-once options within 64 cycles, normal mode
// - Control write clears flag, restarts sequence
// - Group mode ignores two low select bits
// - Select code passed straight through, no reserved codes
module sarseq_top
    import sarseq_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System mode inputs
    input  wire logic        special_mode,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    // Analog front end
    output sarseq_afe_t      afe,
    input  wire logic        comparator_high
);

    logic [7:0]    conv_control_status;
    logic [7:0]    system_config_options;
    logic [7:0]    result_slot [SARSEQ_NUM_SLOTS];
    logic          sequence_done_flag;
    logic          options_written;
    logic [6:0]    reset_age;
    sarseq_state_t state;
    logic [4:0]    cycle_cnt;
    logic [1:0]    slot_idx;
    logic [7:0]    approx;
    logic [7:0]    next_approx;
    logic [11:0]   resume_cnt;
    logic          stop_seen;
    logic          start_pending;
    logic [3:0]    rc_div;
    logic          rc_tick;
    logic          conv_tick;
    logic          ctrl_write;
    logic          opt_write;
    logic          have_aw;
    logic          have_w;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          conv_done;
    logic [1:0]    next_slot;
    logic          seq_end;

    wire conv_power_up          = system_config_options[SARSEQ_OPT_PU_BIT];
    wire conv_clock_select      = system_config_options[SARSEQ_OPT_CONV_CLOCK_SELECT_BIT];
    wire stop_exit_delay_enable = system_config_options[SARSEQ_OPT_DLY_BIT];
    wire group_mode_select      = conv_control_status[SARSEQ_CTL_GRP_BIT];
    wire scan_continuous        = conv_control_status[SARSEQ_CTL_SCAN_BIT];
    wire [3:0] source_select_code = conv_control_status[3:0];

    // Source for a slot; in group mode the slot index gives its low bits
    function automatic logic [3:0] source_for(input logic [3:0] code, input logic grp,
                                              input logic [1:0] idx);
        source_for = grp ? {code[3:2], idx} : code;
    endfunction

    // Conversion clock: bus clock or divided RC stand-in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_div  <= 4'h0;
            rc_tick <= 1'b0;
        end else if (rc_div == SARSEQ_RC_DIV - 4'h1) begin
            rc_div  <= 4'h0;
            rc_tick <= 1'b1;
        end else begin
            rc_div  <= rc_div + 4'h1;
            rc_tick <= 1'b0;
        end
    end
    assign conv_tick = conv_clock_select ? rc_tick : 1'b1;

    // AXI write path: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw      <= 1'b0;
            have_w       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SARSEQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (have_aw && have_w && !s_axi_bvalid) begin
                have_aw      <= 1'b0;
                have_w       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr[7:2] > SARSEQ_OFF_POWER[7:2])
                    s_axi_bresp <= SARSEQ_RESP_SLVERR;
                else
                    s_axi_bresp <= SARSEQ_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !have_aw;
    assign s_axi_wready  = !have_w;

    wire wr_commit = have_aw && have_w && !s_axi_bvalid && w_strb[0];
    always_comb begin
        ctrl_write = 1'b0;
        opt_write  = 1'b0;
        if (wr_commit && aw_addr[7:2] == SARSEQ_OFF_CTRL[7:2])
            ctrl_write = 1'b1;
        else if (wr_commit && aw_addr[7:2] == SARSEQ_OFF_OPTIONS[7:2])
            opt_write = 1'b1;
    end

    // Control register; bits 7 and 6 read back from elsewhere or zero
    always_ff @(posedge aclk) begin
        if (!aresetn)
            conv_control_status <= SARSEQ_CTRL_RST;
        else if (ctrl_write)
            conv_control_status <= {2'b00, w_data[5:0]};
    end

    // Options: write-once window after reset unless in special mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_config_options <= SARSEQ_OPT_RST;
            options_written       <= 1'b0;
            reset_age             <= 7'h00;
        end else begin
            if (reset_age != SARSEQ_WRONCE_CYC)
                reset_age <= reset_age + 7'h1;
            if (opt_write && (special_mode ||
                (!options_written && reset_age < SARSEQ_WRONCE_CYC))) begin
                system_config_options <= w_data[7:0] & SARSEQ_OPT_MASK;
                options_written       <= 1'b1;
            end
        end
    end

    // Start one cycle after the control write
    always_ff @(posedge aclk) begin
        if (!aresetn)
            start_pending <= 1'b0;
        else
            start_pending <= ctrl_write;
    end

    assign conv_done = (state == SARSEQ_RUN) && conv_tick && (cycle_cnt == SARSEQ_CONV_CYC);
    assign next_slot = slot_idx + 2'h1;
    assign seq_end   = conv_done && (slot_idx == 2'(SARSEQ_NUM_SLOTS - 1));

    // Sequencer state, conversion step counter and slot index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= SARSEQ_IDLE;
            cycle_cnt  <= 5'h00;
            slot_idx   <= 2'h0;
            resume_cnt <= 12'h000;
            stop_seen  <= 1'b0;
        end else if (!conv_power_up) begin
            state     <= SARSEQ_IDLE;
            cycle_cnt <= 5'h00;
        end else if (start_pending) begin
            state     <= SARSEQ_RUN;
            cycle_cnt <= 5'h00;
            slot_idx  <= 2'h0;
        end else begin
            case (state)
                SARSEQ_IDLE: begin
                    cycle_cnt <= 5'h00;
                end
                SARSEQ_RUN: begin
                    if (stop_mode || wait_mode) begin
                        state     <= SARSEQ_SUSPEND;
                        stop_seen <= stop_mode;
                        cycle_cnt <= 5'h00;
                    end else if (conv_done) begin
                        cycle_cnt <= 5'h00;
                        slot_idx  <= next_slot;
                        if (seq_end && !scan_continuous)
                            state <= SARSEQ_IDLE;
                    end else if (conv_tick) begin
                        cycle_cnt <= cycle_cnt + 5'h01;
                    end
                end
                SARSEQ_SUSPEND: begin
                    if (stop_mode)
                        stop_seen <= 1'b1;
                    if (!stop_mode && !wait_mode) begin
                        state <= SARSEQ_RESUME;
                        if (stop_seen && stop_exit_delay_enable)
                            resume_cnt <= SARSEQ_DLY_LONG_C;
                        else if (stop_seen)
                            resume_cnt <= SARSEQ_DLY_SHORT_C;
                        else
                            resume_cnt <= 12'h001;
                    end
                end
                SARSEQ_RESUME: begin
                    if (resume_cnt <= 12'h001) begin
                        state     <= SARSEQ_RUN; // restart sample of same channel
                        stop_seen <= 1'b0;
                        cycle_cnt <= 5'h00;
                    end else begin
                        resume_cnt <= resume_cnt - 12'h001;
                    end
                end
                default: state <= SARSEQ_IDLE;
            endcase
        end
    end

    // DAC loads the next trial, so each step compares the code it decides
    always_comb begin
        next_approx = approx;
        if (state == SARSEQ_RUN && conv_tick && !stop_mode && !wait_mode) begin
            if (cycle_cnt == SARSEQ_SAMPLE_CYC - 5'h01) begin
                next_approx = 8'h80;
            end else if (cycle_cnt >= SARSEQ_STEP_FIRST && cycle_cnt <= SARSEQ_STEP_LAST) begin
                for (int b = 0; b < SARSEQ_NUM_BITS; b++) begin
                    if (b == 7 - int'(cycle_cnt - SARSEQ_STEP_FIRST)) begin
                        next_approx[b] = comparator_high;
                        if (b > 0)
                            next_approx[b-1] = 1'b1;
                    end
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            approx <= 8'h00;
        else
            approx <= next_approx;
    end

    // Result slots; written on the aclk edge, reads sample registered copies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SARSEQ_NUM_SLOTS; i++)
                result_slot[i] <= 8'h00;
        end else if (conv_done && !start_pending && conv_power_up) begin
            result_slot[slot_idx] <= approx;
        end
    end

    // Done flag: set at fourth result, cleared by control write (set wins)
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sequence_done_flag <= 1'b0;
        else if (seq_end && !start_pending && conv_power_up)
            sequence_done_flag <= 1'b1;
        else if (ctrl_write)
            sequence_done_flag <= 1'b0;
    end

    // Front end drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            afe <= '0;
        end else begin
            afe.power_up      <= conv_power_up;
            afe.sample_closed <= (state == SARSEQ_RUN) && !stop_mode && !wait_mode &&
                                 (cycle_cnt < SARSEQ_SAMPLE_CYC);
            afe.source_select_code <= source_for(source_select_code, group_mode_select, slot_idx);
            afe.dac_code      <= next_approx;
        end
    end

    // AXI read path; one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= SARSEQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= SARSEQ_RESP_OKAY;
            if (s_axi_araddr[7:2] == SARSEQ_OFF_CTRL[7:2])
                s_axi_rdata <= {24'h0, sequence_done_flag, 1'b0, conv_control_status[5:0]};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_OPTIONS[7:2])
                s_axi_rdata <= {24'h0, system_config_options};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_SLOT1[7:2])
                s_axi_rdata <= {24'h0, result_slot[0]};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_SLOT2[7:2])
                s_axi_rdata <= {24'h0, result_slot[1]};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_SLOT3[7:2])
                s_axi_rdata <= {24'h0, result_slot[2]};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_SLOT4[7:2])
                s_axi_rdata <= {24'h0, result_slot[3]};
            else if (s_axi_araddr[7:2] == SARSEQ_OFF_POWER[7:2])
                s_axi_rdata <= {30'h0, state};
            else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= SARSEQ_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

endmodule

// ### sarseq_asserts.sv
/*
 Port checker for the converter sequencer.
 Assumes control writes come with both channels together, well apart.
*/
`timescale 1ns/10ps
module sarseq_asserts
    import sarseq_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Modes and front end
    input wire logic        stop_mode,
    input wire logic        wait_mode,
    input wire sarseq_afe_t afe
);
    logic       ctl_wr;
    logic       quiet;
    logic       grp_r;
    logic [3:0] run_code;
    logic [2:0] age;
    logic [5:0] smp_cnt;

    assign ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                    && s_axi_awaddr == SARSEQ_OFF_CTRL && s_axi_wstrb[0];
    // Old conversions may still finish just after a write
    assign quiet  = age == 3'h7 && afe.power_up && !stop_mode && !wait_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grp_r    <= 1'b0;
            run_code <= 4'h0;
            age      <= 3'h0;
        end else if (ctl_wr) begin
            grp_r    <= s_axi_wdata[SARSEQ_CTL_GRP_BIT];
            run_code <= s_axi_wdata[4] ? {s_axi_wdata[3:2], 2'b00} : s_axi_wdata[3:0];
            age      <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !afe.sample_closed) smp_cnt <= 6'h00;
        else smp_cnt <= smp_cnt + 6'h01;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ctl_write_s;
        ctl_wr && afe.power_up && !stop_mode && !wait_mode;
    endsequence
    sequence new_sample_s;
        ##[1:12] (afe.sample_closed && afe.source_select_code == run_code);
    endsequence
    sequence full_sample_s;
        $fell(afe.sample_closed) && $past(smp_cnt) >= 6'd11 && quiet && !$past(stop_mode) && !$past(wait_mode);
    endsequence

    seq_start_a: assert property (ctl_write_s |-> new_sample_s)
        else $error("no sample phase after control write");
    sample_len_a: assert property (smp_cnt <= 6'd48)
        else $error("sample switch closed too long");
    power_off_a: assert property (!afe.power_up |-> !afe.sample_closed)
        else $error("sampling while powered down");
    msb_first_a: assert property (full_sample_s |-> $past(afe.dac_code) == 8'h80)
        else $error("first trial is not the top bit");
    group_code_a: assert property ($rose(afe.sample_closed) && grp_r && quiet |-> afe.source_select_code[3:2] == run_code[3:2])
        else $error("source outside selected group");
    stop_hold_a: assert property (stop_mode && $past(stop_mode) |=> $stable(afe.source_select_code))
        else $error("source changed while suspended");
    stop_open_a: assert property (stop_mode [*3] |-> !afe.sample_closed)
        else $error("switch closed while suspended");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
endmodule

// ### sarseq_afe_model.sv
/*
 Behavioural analog front end: input switch, capacitor DAC and comparator.
 Assumes the bench supplies one level byte for each source code.
*/
`timescale 1ns/10ps
module sarseq_afe_model
    import sarseq_pkg::*;
(
    // Clock
    input  wire logic             aclk,
    // Sequencer controls and source levels
    input  wire sarseq_afe_t      afe,
    input  wire logic [15:0][7:0] levels,
    // Comparator decision
    output logic                  comparator_high
);
    logic [7:0] held = 8'h00;
    logic       flip = 1'b0;

    // Charge is taken only while the switch is closed
    always_ff @(posedge aclk) begin
        if (afe.sample_closed && afe.power_up) begin
            held <= levels[afe.source_select_code];
        end
        flip <= ~flip;
    end

    // Unpowered comparator gives no trustworthy answer
    assign comparator_high = afe.power_up ? (held >= afe.dac_code) : flip;
endmodule

// ### sar_adc_sequencer_test.sv
/*
 Self-checking bench for the converter sequencer.
 Assumes the front end model and the checker are compiled before it.
*/
`timescale 1ns/10ps
module sar_adc_sequencer_test
    import sarseq_pkg::*;
;
    logic             aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready, cmp_high, special_mode, stop_mode, wait_mode;
    logic [7:0]       awaddr, araddr;
    logic [31:0]      wdata, rdata, rd;
    logic [3:0]       wstrb;
    logic [1:0]       bresp, rresp, rr;
    logic [5:0]       c;
    sarseq_afe_t      afe;
    logic [15:0][7:0] levels;
    logic [31:0]      seed = 32'h52526a69;
    int               err_total, n_tests, i, m;

    sarseq_top i_sarseq_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .special_mode(special_mode), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .afe(afe), .comparator_high(cmp_high)
    );
    sarseq_afe_model i_sarseq_afe_model (.aclk(aclk), .afe(afe), .levels(levels), .comparator_high(cmp_high));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] exp_slot(input logic [5:0] ctl, input logic [1:0] s);
        return {24'h0, ctl[4] ? levels[{ctl[3:2], s}] : levels[ctl[3:0]]};
    endfunction
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tmo();
        err_total++;
        final_report();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int   k;
        logic aw_t, w_t;
        aw_t = 1'b0;
        w_t  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 50 && !(aw_t && w_t); k++) begin
            @(negedge aclk);
            aw_t = aw_t || (awvalid && awready);
            w_t  = w_t || (wvalid && wready);
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        for (k = 0; k < 50; k++) begin
            @(negedge aclk);
            if (bvalid) break;
        end
        if (k == 50) tmo();
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int k;
        void'(rnd());
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= seed[0];
        for (k = 0; k < 50; k++) begin
            @(negedge aclk);
            if (arready) break;
        end
        if (k == 50) tmo();
        @(posedge aclk);
        arvalid <= 1'b0;
        for (k = 0; k < 50; k++) begin
            @(negedge aclk);
            if (rvalid && rready) break;
            @(posedge aclk);
            rready <= 1'b1;
        end
        if (k == 50) tmo();
        rd = rdata;
        rr = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 3000; k++) begin
            axi_rd(SARSEQ_OFF_CTRL);
            if (rd[7] === 1'b1) break;
        end
        if (k == 3000) tmo();
    endtask

    task automatic check_slots(input logic [5:0] ctl);
        int s;
        for (s = 0; s < 4; s++) begin
            axi_rd(SARSEQ_OFF_SLOT1 + 8'(4 * s));
            check(rd, exp_slot(ctl, 2'(s)));
        end
    endtask

    task automatic run(input logic [5:0] ctl);
        axi_wr(SARSEQ_OFF_CTRL, {26'h0, ctl}, 4'hf);
        axi_rd(SARSEQ_OFF_CTRL);
        check(rd, {26'h0, ctl});
        wait_done();
        check(rd, {24'h0, 2'b10, ctl});
        check_slots(ctl);
    endtask

    // Slots must follow new levels once a full pass has gone by
    task automatic recheck(input logic [5:0] ctl);
        for (i = 0; i < 12; i++) levels[i] <= 8'(rnd());
        repeat (300) @(posedge aclk);
        check_slots(ctl);
    endtask

    task automatic pause(input logic stp, input int gap, input logic [31:0] st);
        axi_wr(SARSEQ_OFF_CTRL, 32'h05, 4'hf);
        repeat (40) @(posedge aclk);
        stop_mode <= stp;
        wait_mode <= !stp;
        repeat (10) @(posedge aclk);
        axi_rd(SARSEQ_OFF_POWER);
        check(rd, 32'h2);
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        repeat (gap) @(posedge aclk);
        axi_rd(SARSEQ_OFF_POWER);
        check(rd, st);
        wait_done();
        check_slots(6'h05);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, special_mode, stop_mode, wait_mode} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        for (i = 0; i < 16; i++) levels[i] = 8'(rnd());
        levels[12] = 8'hff;
        levels[13] = 8'h00;
        levels[14] = 8'h80;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(SARSEQ_OFF_CTRL);
        check(rd, {24'h0, SARSEQ_CTRL_RST});
        axi_rd(SARSEQ_OFF_OPTIONS);
        check(rd, {24'h0, SARSEQ_OPT_RST});
        axi_rd(8'h1c);
        check({30'h0, rr}, {30'h0, SARSEQ_RESP_SLVERR});
        axi_wr(SARSEQ_OFF_OPTIONS, 32'h90, 4'hf);
        axi_wr(SARSEQ_OFF_OPTIONS, 32'h00, 4'hf);
        axi_rd(SARSEQ_OFF_OPTIONS);
        check(rd, 32'h90);
        run(6'h0c);
        run(6'h0d);
        run(6'h3c);
        recheck(6'h3c);
        for (m = 0; m < 8; m++) begin
            void'(rnd());
            c = {2'(m), 1'b0, seed[2:0]};
            run(c);
            if (m[1]) recheck(c);
        end
        run(6'h07);
        axi_wr(SARSEQ_OFF_SLOT1, 32'hff, 4'hf);
        axi_wr(SARSEQ_OFF_CTRL, 32'h10, 4'h0);
        axi_rd(SARSEQ_OFF_CTRL);
        check(rd, 32'h87);
        check_slots(6'h07);
        pause(1'b1, 2000, 32'h3);
        special_mode <= 1'b1;
        axi_wr(SARSEQ_OFF_OPTIONS, 32'h80, 4'hf);
        axi_rd(SARSEQ_OFF_OPTIONS);
        check(rd, 32'h80);
        pause(1'b1, 10, 32'h1);
        pause(1'b0, 10, 32'h1);
        axi_wr(SARSEQ_OFF_OPTIONS, 32'hc0, 4'hf);
        run(6'h16);
        axi_wr(SARSEQ_OFF_OPTIONS, 32'h40, 4'hf);
        axi_rd(SARSEQ_OFF_POWER);
        check(rd, 32'h0);
        check({31'h0, afe.power_up}, 32'h0);
        final_report();
    end
endmodule

bind sarseq_top sarseq_asserts i_sarseq_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stop_mode(stop_mode), .wait_mode(wait_mode), .afe(afe)
);
